/* verilog/uart_mp_pkg.sv */
// Constants, types and state encodings for the multiprocessor serial port.
// Assumes an 8-bit special-function register bus and timer-1 tick inputs.

package uart_mp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR  = 8'h98;
  localparam logic [7:0] DATA_ADDR  = 8'h99;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int FRAME_WIDTH_BIT = 7;
  localparam int UNUSED_BIT      = 6;
  localparam int MULTIPROC_BIT   = 5;
  localparam int RX_ENABLE_BIT   = 4;
  localparam int TX_NINTH_BIT    = 3;
  localparam int RX_NINTH_BIT    = 2;
  localparam int TX_DONE_BIT     = 1;
  localparam int RX_DONE_BIT     = 0;

  // ----------------------------------------------------------------------
  // Frame counts
  // ----------------------------------------------------------------------
  localparam logic [3:0] BITS_8   = 4'h8;
  localparam logic [3:0] BITS_9   = 4'h9;
  localparam logic [3:0] CNT_ONE  = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_word_s;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_WAIT  = 2'h1,
    TX_SHIFT = 2'h3,
    TX_STOP  = 2'h2
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } rx_state_e;

endpackage : uart_mp_pkg

/* verilog/baud_timer.sv */
// Eight-bit auto-reload bit timer, one instance per direction.
// Assumes tick_i is a one-cycle timer clock enable from the prescaler.
`timescale 1ns/1ns

module baud_timer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // Timing control
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire logic             force_reload_i,
  input  wire logic [WIDTH-1:0] reload_i,
  // Overflow pulse
  output logic                  ovf_o
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             ovf;
  } timer_s;

  timer_s s;
  timer_s next_s;

  // ----------------------------------------------------------------------
  // Count up, reload on wrap or on demand
  // ----------------------------------------------------------------------
  always_comb begin
    next_s     = s;
    next_s.ovf = 1'b0;
    if (force_reload_i) begin
      next_s.count = reload_i;
    end else if (run_i && tick_i) begin
      if (s.count == {WIDTH{1'b1}}) begin
        next_s.count = reload_i;
        next_s.ovf   = 1'b1;
      end else begin
        next_s.count = s.count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ovf_o = s.ovf;

endmodule : baud_timer

/* verilog/rx_word_buffer.sv */
// Small FIFO between the receive shifter and the receive latch.
// Assumes DEPTH is a power of two; full and empty come from the level.
`timescale 1ns/1ns

module rx_word_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd_ptr;
    logic [AW-1:0]               wr_ptr;
    logic [AW:0]                 level;
  } buf_s;

  buf_s s;
  buf_s next_s;
  logic push;
  logic pop;

  assign in_ready_o  = (s.level != FULL);
  assign out_valid_o = (s.level != '0);
  assign out_data_o  = s.mem[s.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // ----------------------------------------------------------------------
  // Pointer and level update
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr        = s.wr_ptr + AW'(1);
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + AW'(1);
    end
    next_s.level = s.level + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : rx_word_buffer

/* verilog/uart_multiprocessor_port.sv */
// Full-duplex serial port with 8/9-bit framing and address filtering.
// Assumes timer-1 ticks and reload value come from outside; pins are
// synchronous to CLK_I.
`timescale 1ns/1ns

module uart_multiprocessor_port (
  // Clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 RESETN_I,
  // Register bus
  input  wire uart_mp_pkg::sfr_req_s SFR_REQ_I,
  output logic [7:0]                SFR_RDATA_O,
  // Bit timing
  input  wire logic                 TIMER_RUN_I,
  input  wire logic                 TIMER_TICK_I,
  input  wire logic [7:0]           BAUD_RELOAD_VALUE_I,
  // Interrupt
  input  wire logic                 INT_ENABLE_I,
  output logic                      IRQ_O,
  // Serial pins
  input  wire logic                 SERIAL_IN_PIN_I,
  output logic                      SERIAL_OUT_PIN_O
);

  import uart_mp_pkg::*;

  typedef struct packed {
    logic       frame_width_select;
    logic       multiproc_check_enable;
    logic       receiver_enable;
    logic       tx_ninth_bit;
    logic       rx_ninth_bit;
    logic       tx_done_flag;
    logic       rx_done_flag;
    logic [7:0] rx_latch;
    tx_state_e  tx_st;
    logic [3:0] tx_cnt;
    logic [8:0] tx_shift;
    logic       tx_phase;
    logic       tx_pin;
    rx_state_e  rx_st;
    logic [3:0] rx_cnt;
    logic [8:0] rx_shift;
    logic       rx_phase;
    logic       rx_prev;
    logic [7:0] rdata;
    logic       irq;
  } port_s;

  port_s      s;
  port_s      next_s;

  logic [7:0] ctrl;
  logic [7:0] wv;
  logic       ctrl_hit;
  logic       data_hit;
  logic       ctrl_wr;
  logic       data_wr;
  logic       tx_ovf;
  logic       rx_ovf;
  logic       tx_tick;
  logic       rx_sample;
  logic       start_edge;
  logic       stop_time;
  logic       accept;
  logic       push_valid;
  logic       push_ready;
  logic       pop_valid;
  logic       pop;
  rx_word_s   push_word;
  rx_word_s   pop_word;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  assign ctrl = {s.frame_width_select,
                 1'b1,
                 s.multiproc_check_enable,
                 s.receiver_enable,
                 s.tx_ninth_bit,
                 s.rx_ninth_bit,
                 s.tx_done_flag,
                 s.rx_done_flag};

  assign ctrl_hit = (SFR_REQ_I.addr == CTRL_ADDR);
  assign data_hit = (SFR_REQ_I.addr == DATA_ADDR);
  assign ctrl_wr  = ctrl_hit && (SFR_REQ_I.wr || SFR_REQ_I.bit_wr);
  assign data_wr  = data_hit && SFR_REQ_I.wr;

  // ----------------------------------------------------------------------
  // Bit clocks
  // ----------------------------------------------------------------------
  baud_timer #(
    .WIDTH (8)
  ) u_tx_timer (
    .clk_i          (CLK_I),
    .rstn_i         (RESETN_I),
    .run_i          (TIMER_RUN_I),
    .tick_i         (TIMER_TICK_I),
    .force_reload_i (1'b0),
    .reload_i       (BAUD_RELOAD_VALUE_I),
    .ovf_o          (tx_ovf)
  );

  baud_timer #(
    .WIDTH (8)
  ) u_rx_timer (
    .clk_i          (CLK_I),
    .rstn_i         (RESETN_I),
    .run_i          (TIMER_RUN_I),
    .tick_i         (TIMER_TICK_I),
    .force_reload_i (start_edge),
    .reload_i       (BAUD_RELOAD_VALUE_I),
    .ovf_o          (rx_ovf)
  );

  assign tx_tick    = tx_ovf && s.tx_phase;
  assign rx_sample  = rx_ovf && !s.rx_phase;
  assign start_edge = s.receiver_enable && (s.rx_st == RX_IDLE) &&
                      s.rx_prev && !SERIAL_IN_PIN_I;

  // ----------------------------------------------------------------------
  // Received word and acceptance check
  // ----------------------------------------------------------------------
  assign stop_time = rx_sample && (s.rx_st == RX_STOP);
  assign push_word.ninth = s.frame_width_select ? s.rx_shift[8]
                                                : SERIAL_IN_PIN_I;
  assign push_word.data  = s.frame_width_select ? s.rx_shift[7:0]
                                                : s.rx_shift[8:1];
  assign accept     = !s.multiproc_check_enable || push_word.ninth;
  assign push_valid = stop_time && accept && push_ready;
  assign pop        = pop_valid && !s.rx_done_flag;

  rx_word_buffer #(
    .WIDTH ($bits(rx_word_s)),
    .DEPTH (2)
  ) u_rx_buffer (
    .clk_i       (CLK_I),
    .rstn_i      (RESETN_I),
    .in_valid_i  (push_valid),
    .in_data_i   (push_word),
    .in_ready_o  (push_ready),
    .out_valid_o (pop_valid),
    .out_data_o  (pop_word),
    .out_ready_i (!s.rx_done_flag)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.rx_prev = SERIAL_IN_PIN_I;
    wv             = ctrl;
    if (SFR_REQ_I.wr) begin
      wv = SFR_REQ_I.wdata;
    end else if (SFR_REQ_I.bit_wr) begin
      wv[SFR_REQ_I.bit_sel] = SFR_REQ_I.bit_val;
    end

    // Software write; bit 6 has no storage
    if (ctrl_wr) begin
      next_s.frame_width_select     = wv[FRAME_WIDTH_BIT];
      next_s.multiproc_check_enable = wv[MULTIPROC_BIT];
      next_s.receiver_enable        = wv[RX_ENABLE_BIT];
      next_s.tx_ninth_bit           = wv[TX_NINTH_BIT];
      next_s.rx_ninth_bit           = wv[RX_NINTH_BIT];
      next_s.tx_done_flag           = wv[TX_DONE_BIT];
      next_s.rx_done_flag           = wv[RX_DONE_BIT];
    end

    if (SFR_REQ_I.rd) begin
      if (ctrl_hit) begin
        next_s.rdata = ctrl;
      end else if (data_hit) begin
        next_s.rdata = s.rx_latch;
      end else begin
        next_s.rdata = ZERO_BYTE;
      end
    end

    // Transmitter
    if (tx_ovf) begin
      next_s.tx_phase = !s.tx_phase;
    end
    unique case (s.tx_st)
      TX_IDLE: begin
        if (data_wr) begin
          next_s.tx_shift = {s.tx_ninth_bit && s.frame_width_select,
                             SFR_REQ_I.wdata};
          next_s.tx_cnt   = s.frame_width_select ? BITS_9
                                                 : BITS_8;
          next_s.tx_st    = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tx_tick) begin
          next_s.tx_pin = 1'b0;
          next_s.tx_st  = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_tick) begin
          if (s.tx_cnt == CNT_ZERO) begin
            next_s.tx_pin       = 1'b1;
            next_s.tx_done_flag = 1'b1;
            next_s.tx_st        = TX_STOP;
          end else begin
            next_s.tx_pin   = s.tx_shift[0];
            next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
            next_s.tx_cnt   = s.tx_cnt - CNT_ONE;
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          next_s.tx_st = TX_IDLE;
        end
      end
    endcase

    // Receiver
    if (start_edge) begin
      next_s.rx_phase = 1'b0;
      next_s.rx_st    = RX_START;
    end else if (rx_ovf) begin
      next_s.rx_phase = !s.rx_phase;
    end
    unique case (s.rx_st)
      RX_IDLE: begin
      end
      RX_START: begin
        if (rx_sample) begin
          if (SERIAL_IN_PIN_I) begin
            next_s.rx_st = RX_IDLE;
          end else begin
            next_s.rx_cnt = s.frame_width_select ? BITS_9
                                                 : BITS_8;
            next_s.rx_st  = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (rx_sample) begin
          next_s.rx_shift = {SERIAL_IN_PIN_I, s.rx_shift[8:1]};
          next_s.rx_cnt   = s.rx_cnt - CNT_ONE;
          if (s.rx_cnt == CNT_ONE) begin
            next_s.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_sample) begin
          next_s.rx_st = RX_IDLE;
        end
      end
    endcase
    if (!s.receiver_enable) begin
      next_s.rx_st = RX_IDLE;
    end

    // Hand the buffered word to the latch; hardware set beats clear
    if (pop) begin
      next_s.rx_latch     = pop_word.data;
      next_s.rx_ninth_bit = pop_word.ninth;
      next_s.rx_done_flag = 1'b1;
    end

    next_s.irq = INT_ENABLE_I &&
                 (s.tx_done_flag || s.rx_done_flag);
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s          <= '0;
      s.rx_latch <= DATA_RESET;
      s.tx_pin   <= 1'b1;
      s.rx_prev  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign SFR_RDATA_O      = s.rdata;
  assign IRQ_O            = s.irq;
  assign SERIAL_OUT_PIN_O = s.tx_pin;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_unused_reads_one;
    @(posedge CLK_I) disable iff (!RESETN_I)
      SFR_REQ_I.rd && ctrl_hit |=> SFR_RDATA_O[UNUSED_BIT];
  endproperty
  a_unused_reads_one: assert property (p_unused_reads_one)
    else $error("Unused control bit read as zero");

  property p_rx_flag_sw_clear;
    @(posedge CLK_I) disable iff (!RESETN_I)
      $fell(s.rx_done_flag) |-> $past(ctrl_wr);
  endproperty
  a_rx_flag_sw_clear: assert property (p_rx_flag_sw_clear)
    else $error("Receive flag cleared without a write");

  property p_tx_flag_at_stop;
    @(posedge CLK_I) disable iff (!RESETN_I)
      s.tx_st == TX_SHIFT && tx_tick && s.tx_cnt == CNT_ZERO
      |=> s.tx_done_flag && s.tx_pin && s.tx_st == TX_STOP;
  endproperty
  a_tx_flag_at_stop: assert property (p_tx_flag_at_stop)
    else $error("Transmit flag not set at stop bit");

  property p_addr_filter;
    @(posedge CLK_I) disable iff (!RESETN_I)
      stop_time && s.frame_width_select && s.multiproc_check_enable &&
      !s.rx_shift[8] |-> !push_valid;
  endproperty
  a_addr_filter: assert property (p_addr_filter)
    else $error("Data byte accepted under address filter");

  property p_stop_check;
    @(posedge CLK_I) disable iff (!RESETN_I)
      stop_time && !s.frame_width_select && s.multiproc_check_enable &&
      !SERIAL_IN_PIN_I |-> !push_valid;
  endproperty
  a_stop_check: assert property (p_stop_check)
    else $error("Byte with bad stop bit accepted");

  property p_rx_disabled;
    @(posedge CLK_I) disable iff (!RESETN_I)
      !s.receiver_enable ##1 !s.receiver_enable |-> s.rx_st == RX_IDLE;
  endproperty
  a_rx_disabled: assert property (p_rx_disabled)
    else $error("Receiver active while disabled");

  property p_tx_ninth;
    @(posedge CLK_I) disable iff (!RESETN_I)
      data_wr && s.tx_st == TX_IDLE && s.frame_width_select
      |=> s.tx_shift[8] == $past(s.tx_ninth_bit);
  endproperty
  a_tx_ninth: assert property (p_tx_ninth)
    else $error("Ninth transmit bit not taken from control");

  property p_irq;
    @(posedge CLK_I) disable iff (!RESETN_I)
      INT_ENABLE_I && (s.tx_done_flag || s.rx_done_flag) |=> IRQ_O;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt not raised for set flag");

  property p_no_load_when_full;
    @(posedge CLK_I) disable iff (!RESETN_I)
      s.rx_done_flag && !ctrl_wr |=> $stable(s.rx_latch);
  endproperty
  a_no_load_when_full: assert property (p_no_load_when_full)
    else $error("Receive latch changed while flag set");

  property p_rx_load;
    @(posedge CLK_I) disable iff (!RESETN_I)
      pop |=> s.rx_done_flag && s.rx_latch == $past(pop_word.data);
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("Accepted byte not latched with flag");

  property p_data_read;
    @(posedge CLK_I) disable iff (!RESETN_I)
      SFR_REQ_I.rd && data_hit |=> SFR_RDATA_O == $past(s.rx_latch);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("Data read did not return receive latch");

  property p_start_reload;
    @(posedge CLK_I) disable iff (!RESETN_I)
      start_edge |=> s.rx_st == RX_START && !s.rx_phase;
  endproperty
  a_start_reload: assert property (p_start_reload)
    else $error("Start edge did not restart receiver");

  property p_tx_start;
    @(posedge CLK_I) disable iff (!RESETN_I)
      data_wr && s.tx_st == TX_IDLE |=> s.tx_st == TX_WAIT;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("Data write did not start transmission");

endmodule : uart_multiprocessor_port

/* tb/uart_peer_model.sv */
// Serial peer on the far side of the port: sends and takes frames.
// Assumes a bit time of BIT clock cycles and an idle-high line.
`timescale 1ns/1ns

module uart_peer_model #(
  parameter int BIT = 8
) (
  // Clock
  input  wire logic clk_i,
  // Serial line
  input  wire logic line_i,
  output logic      line_o
);
  // --------------------------------------------------------------------
  // Frame sender
  // --------------------------------------------------------------------
  initial line_o = 1'b1;

  task automatic send(input bit nine, input logic [7:0] d,
                      input logic nb, input logic sb);
    logic [10:0] f;
    int          n;
    f = nine ? {sb, nb, d, 1'b0} : {1'b1, sb, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      line_o = f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    #1;
    line_o = 1'b1;
    repeat (BIT) @(posedge clk_i);
  endtask : send

  // --------------------------------------------------------------------
  // Frame taker: samples mid-bit; v[8] is ninth bit or stop bit
  // --------------------------------------------------------------------
  task automatic recv(input bit nine, output logic [8:0] v);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk_i);
      v[i] = line_i;
    end
  endtask : recv

endmodule : uart_peer_model

/* tb/uart_multiprocessor_port_tb.sv */
// Self-checking bench: register tasks plus a serial peer model.
// Assumes timer ticks every cycle, so a bit lasts 2*(256-RELOAD) cycles.
`timescale 1ns/1ns

module uart_multiprocessor_port_tb;
  import uart_mp_pkg::*;

  localparam logic [7:0] RELOAD = 8'hFC;
  localparam int         BIT    = 2 * (256 - int'(RELOAD));

  logic       clk;
  logic       rst_n;
  logic       int_en;
  logic       irq;
  logic       sin;
  logic       sout;
  logic [7:0] rdata;
  sfr_req_s   req;
  int         n_fail;
  int         checked;

  uart_multiprocessor_port i_dut (
    .CLK_I               (clk),
    .RESETN_I            (rst_n),
    .SFR_REQ_I           (req),
    .SFR_RDATA_O         (rdata),
    .TIMER_RUN_I         (1'b1),
    .TIMER_TICK_I        (1'b1),
    .BAUD_RELOAD_VALUE_I (RELOAD),
    .INT_ENABLE_I        (int_en),
    .IRQ_O               (irq),
    .SERIAL_IN_PIN_I     (sin),
    .SERIAL_OUT_PIN_O    (sout)
  );

  uart_peer_model #(.BIT(BIT)) i_peer (
    .clk_i  (clk),
    .line_i (sout),
    .line_o (sin)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // --------------------------------------------------------------------
  // Register access and checking
  // --------------------------------------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
  endtask : wr

  task automatic bitw(input logic [2:0] s, input logic v);
    @(posedge clk);
    #1;
    req.bit_wr = 1'b1;
    req.addr = CTRL_ADDR;
    req.bit_sel = s;
    req.bit_val = v;
    @(posedge clk);
    #1;
    req.bit_wr = 1'b0;
  endtask : bitw

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    chk({1'b0, rdata}, {1'b0, e});
  endtask : rd

  // --------------------------------------------------------------------
  // Transmit and receive cases
  // --------------------------------------------------------------------
  task automatic tx_case(input logic [7:0] c, input logic [7:0] d,
                         input logic [8:0] ev);
    logic [8:0] v;
    wr(CTRL_ADDR, c);
    wr(DATA_ADDR, d);
    i_peer.recv(c[7], v);
    chk(v, ev);
    repeat (BIT) @(posedge clk);
    chk({8'h00, sout}, 9'h001);
    rd(CTRL_ADDR, c | 8'h42);
    chk({8'h00, irq}, {8'h00, int_en});
    wr(CTRL_ADDR, c);
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, irq}, 9'h000);
  endtask : tx_case

  task automatic rx_case(input logic [7:0] c, input bit nine,
                         input logic [7:0] d, input logic nb,
                         input logic sb, input bit acc);
    logic [7:0] ec;
    ec = c | 8'h40;
    if (acc) ec = (ec & 8'hFB) | {5'h00, nine ? nb : sb, 2'b01};
    wr(CTRL_ADDR, c);
    i_peer.send(nine, d, nb, sb);
    rd(CTRL_ADDR, ec);
    if (acc) rd(DATA_ADDR, d);
    wr(CTRL_ADDR, c);
  endtask : rx_case

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    n_fail = 0;
    checked = 0;
    req = '0;
    int_en = 1'b1;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(CTRL_ADDR, 8'h40);
    rd(DATA_ADDR, 8'h00);
    rd(8'h9A, 8'h00);
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h40);
    tx_case(8'h00, 8'hA5, 9'h1A5);
    tx_case(8'h88, 8'h3C, 9'h13C);
    int_en = 1'b0;
    tx_case(8'h80, 8'hC3, 9'h0C3);
    int_en = 1'b1;
    tx_case(8'h08, 8'h5A, 9'h15A);
    rx_case(8'h10, 0, 8'h3C, 0, 1, 1);
    rx_case(8'h10, 0, 8'h5A, 0, 0, 1);
    rx_case(8'h30, 0, 8'h66, 0, 0, 0);
    rx_case(8'h30, 0, 8'hE1, 0, 1, 1);
    rx_case(8'hB0, 1, 8'h24, 0, 1, 0);
    rx_case(8'hB0, 1, 8'h42, 1, 1, 1);
    rx_case(8'h90, 1, 8'h77, 0, 1, 1);
    rx_case(8'h80, 1, 8'h99, 1, 1, 0);
    wr(CTRL_ADDR, 8'h10);
    i_peer.send(0, 8'h81, 0, 1);
    i_peer.send(0, 8'h18, 0, 1);
    rd(DATA_ADDR, 8'h81);
    bitw(3'(RX_DONE_BIT), 1'b0);
    repeat (3) @(posedge clk);
    rd(DATA_ADDR, 8'h18);
    rd(CTRL_ADDR, 8'h55);
    give_verdict();
  end

endmodule : uart_multiprocessor_port_tb
